// [core/irq_prio_pkg.sv]
// Constants for the interrupt priority and autovector block
package irq_prio_pkg;
  // Source counts
  localparam int NUM_INT = 10;
  localparam int NUM_EXT = 4;
  localparam int NUM_SRC = 14;
  // Register offsets (word aligned byte addresses)
  localparam logic [7:0] OFS_SRC_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_EXT_AUTOVECTOR_SELECT = 8'h28;
  localparam logic [7:0] OFS_LEVEL_ASSIGN = 8'h2C;
  localparam logic [7:0] OFS_MASK = 8'h30;
  localparam logic [7:0] OFS_PENDING = 8'h34;
  localparam logic [7:0] OFS_ACK_INFO = 8'h38;
  // Source control entry fields
  localparam int CTL_AUTOVECTOR_SELECT_BIT = 7;
  localparam int CTL_LVL_HI = 4;
  localparam int CTL_LVL_LO = 2;
  localparam int CTL_PRI_HI = 1;
  localparam int CTL_PRI_LO = 0;
  localparam logic [7:0] CTL_WR_MASK = 8'h9F;
  // Autovector control fields
  localparam int AV_BLOCK_BIT = 0;
  // External level assign bits
  localparam int ASSIGN_FIVE_BIT = 2;
  localparam int ASSIGN_THREE_BIT = 1;
  localparam int ASSIGN_ONE_BIT = 0;
  // Reset values
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] AUTOVECTOR_SELECT_RESET = 8'h00;
  localparam logic [2:0] ASSIGN_RESET = 3'h0;
  localparam logic [13:0] MASK_RESET = 14'h3FFF;
  // Autovector offsets
  localparam logic [7:0] AUTOVEC_BASE = 8'h60;
  localparam logic [7:0] AUTOVEC_STEP = 8'h04;
  // Rank within a level: 0 = best
  localparam logic [2:0] RANK_EXT = 3'h2;
  localparam logic [2:0] RANK_NONE = 3'h7;
endpackage

// [core/irq_sync2.sv]
// Two-stage synchroniser for one pin
`timescale 1ns/100ps
`default_nettype none
module irq_sync2 (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Pin in, level out
  input wire logic pin_in,
  output logic level_out
);
  logic meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_r <= 1'b0;
      level_out <= 1'b0;
    end
    else
    begin
      meta_r <= pin_in;
      level_out <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [core/irq_slot_rank.sv]
// Ranks one source: slot key where larger is served first
`timescale 1ns/100ps
`default_nettype none
module irq_slot_rank (
  // Source state
  input wire logic active,
  input wire logic [2:0] level,
  input wire logic [2:0] rank,
  // Key: level above, inverted rank below, zero when idle
  output logic [5:0] key
);
  // Level dominates rank, so 35 slots order cleanly
  always_comb
  begin
    if (active && (level != 3'h0))
      key = {level, 3'h4 - rank};
    else
      key = 6'h00;
  end
endmodule
`default_nettype wire

// [core/irq_prio_ctrl.sv]
// Interrupt priority resolver with autovector selection
//
// Behaviour
// - Within a level: internal 11, 10, external pin, 01, 00.
// - Higher levels always beat lower levels; seven is highest, 35 slots.
// - Pin seven is fixed at level seven, between codes 10 and 01.
// - Pin five maps to level five, or four when assign bit two set.
// - Pin three maps to level three, or six when assign bit one set.
// - Pin one maps to level one, or two when assign bit zero set.
// - Internal three-bit level code is used as the level number directly.
// - Autovector control bits seven to one choose autovector per external level.
// - External autovector offset is 0x64 for level one, plus four per level.
// - Bit zero set blocks the bus cycle strobe during autovector acknowledge.
// - Per-level autovector bit counts only for a level the pins actually use.
// - Internal sources take autovector choice from their own control entry.
// - Entry holds autovector bit 7, level bits 4-2, priority bits 1-0.
// - Masked sources still record pending but raise no request to core.
`timescale 1ns/100ps
`default_nettype none
module irq_prio_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Internal source request levels
  input wire logic [9:0] int_req,
  // External request pins, active low
  input wire logic ext_request_pin_seven_n,
  input wire logic ext_request_pin_five_n,
  input wire logic ext_request_pin_three_n,
  input wire logic ext_request_pin_one_n,
  // Core side
  output logic [2:0] core_level,
  input wire logic ack_req,
  input wire logic [2:0] ack_level,
  // Acknowledge answer
  output logic ack_done,
  output logic ack_autovec,
  output logic [7:0] ack_vec_offset,
  output logic [3:0] ack_source,
  output logic ack_none,
  output logic bus_cycle_strobe_block
);
  // ---------------------------------------------
  // Storage
  // ---------------------------------------------
  logic [7:0] source_priority_control_r [irq_prio_pkg::NUM_INT];
  logic [7:0] external_autovector_control_r;
  logic [2:0] external_level_assign_r;
  logic [13:0] mask_bits_r;
  logic [13:0] pending_bits_r;
  logic [3:0] ext_sync;
  logic [13:0] src_active;
  logic [2:0] src_level [irq_prio_pkg::NUM_SRC];
  logic [2:0] src_rank [irq_prio_pkg::NUM_SRC];
  logic [5:0] src_key [irq_prio_pkg::NUM_SRC];
  logic [5:0] best_key;
  logic [3:0] best_idx;
  logic [5:0] ack_key;
  logic [3:0] ack_idx;
  logic ack_hit;
  logic ack_av_sel;
  logic [7:0] ack_off_nxt;
  logic [31:0] rdata_nxt;

  // ---------------------------------------------
  // Pin synchronisers (pins are active low)
  // ---------------------------------------------
  irq_sync2 u_sync_seven (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(~ext_request_pin_seven_n),
    .level_out(ext_sync[3])
  );
  irq_sync2 u_sync_five (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(~ext_request_pin_five_n),
    .level_out(ext_sync[2])
  );
  irq_sync2 u_sync_three (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(~ext_request_pin_three_n),
    .level_out(ext_sync[1])
  );
  irq_sync2 u_sync_one (
    .clk(clk),
    .sys_rst(sys_rst),
    .pin_in(~ext_request_pin_one_n),
    .level_out(ext_sync[0])
  );

  // ---------------------------------------------
  // Register writes
  // ---------------------------------------------
  // Source control entries; reserved bits 6-5 kept clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < irq_prio_pkg::NUM_INT; i++)
        source_priority_control_r[i] <= irq_prio_pkg::CTL_RESET;
    end
    else if (reg_wr)
    begin
      for (int i = 0; i < irq_prio_pkg::NUM_INT; i++)
        if (reg_addr == irq_prio_pkg::OFS_SRC_CTRL0 + 8'(4 * i))
          source_priority_control_r[i] <= reg_wdata[7:0] & irq_prio_pkg::CTL_WR_MASK;
    end
  end

  // Autovector control, level assign and mask
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      external_autovector_control_r <= irq_prio_pkg::AUTOVECTOR_SELECT_RESET;
      external_level_assign_r <= irq_prio_pkg::ASSIGN_RESET;
      mask_bits_r <= irq_prio_pkg::MASK_RESET;
    end
    else if (reg_wr)
    begin
      if (reg_addr == irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT)
        external_autovector_control_r <= reg_wdata[7:0];
      if (reg_addr == irq_prio_pkg::OFS_LEVEL_ASSIGN)
        external_level_assign_r <= reg_wdata[2:0];
      if (reg_addr == irq_prio_pkg::OFS_MASK)
        mask_bits_r <= reg_wdata[13:0];
    end
  end

  // Pending samples every source each clock, mask or not
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pending_bits_r <= 14'h0000;
    else
      pending_bits_r <= {ext_sync, int_req};
  end

  // ---------------------------------------------
  // Slot mapping per source
  // ---------------------------------------------
  // Internal: level code is the level, rank from priority code
  always_comb
  begin
    for (int i = 0; i < irq_prio_pkg::NUM_INT; i++)
    begin
      src_level[i] = source_priority_control_r[i][irq_prio_pkg::CTL_LVL_HI:irq_prio_pkg::CTL_LVL_LO];
      // 11 -> 0, 10 -> 1, 01 -> 3, 00 -> 4; rank 2 left for the pin
      case (source_priority_control_r[i][irq_prio_pkg::CTL_PRI_HI:irq_prio_pkg::CTL_PRI_LO])
        2'b11: src_rank[i] = 3'h0;
        2'b10: src_rank[i] = 3'h1;
        2'b01: src_rank[i] = 3'h3;
        default: src_rank[i] = 3'h4;
      endcase
    end
    // External pins sit between codes 10 and 01
    src_level[10] = 3'h1 + {2'b00, external_level_assign_r[irq_prio_pkg::ASSIGN_ONE_BIT]};
    src_level[11] = external_level_assign_r[irq_prio_pkg::ASSIGN_THREE_BIT] ? 3'h6 : 3'h3;
    src_level[12] = external_level_assign_r[irq_prio_pkg::ASSIGN_FIVE_BIT] ? 3'h4 : 3'h5;
    src_level[13] = 3'h7;
    for (int e = 10; e < irq_prio_pkg::NUM_SRC; e++)
      src_rank[e] = irq_prio_pkg::RANK_EXT;
  end

  // Masked sources never reach the resolver
  assign src_active = pending_bits_r & ~mask_bits_r;

  genvar g;
  generate
    for (g = 0; g < irq_prio_pkg::NUM_SRC; g++)
    begin : g_rank
      irq_slot_rank u_rank (
        .active(src_active[g]),
        .level(src_level[g]),
        .rank(src_rank[g]),
        .key(src_key[g])
      );
    end
  endgenerate

  // ---------------------------------------------
  // Resolution
  // ---------------------------------------------
  // Overall winner: largest key, level first
  always_comb
  begin
    best_key = 6'h00;
    best_idx = 4'h0;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
      if (src_key[i] > best_key)
      begin
        best_key = src_key[i];
        best_idx = 4'(i);
      end
  end

  // Winner restricted to the acknowledged level
  always_comb
  begin
    ack_key = 6'h00;
    ack_idx = 4'h0;
    for (int i = 0; i < irq_prio_pkg::NUM_SRC; i++)
      if ((src_key[i] > ack_key) && (src_key[i][5:3] == ack_level))
      begin
        ack_key = src_key[i];
        ack_idx = 4'(i);
      end
  end
  assign ack_hit = (ack_key != 6'h00);

  // Autovector choice: own entry for internal, per-level bit for pins
  always_comb
  begin
    if (ack_idx < 4'(irq_prio_pkg::NUM_INT))
      ack_av_sel = source_priority_control_r[ack_idx][irq_prio_pkg::CTL_AUTOVECTOR_SELECT_BIT];
    else
      // Pin level follows the assignment, so only an enabled level is consulted
      ack_av_sel = external_autovector_control_r[src_level[ack_idx]];
    ack_off_nxt = irq_prio_pkg::AUTOVEC_BASE + 8'(src_level[ack_idx]) * irq_prio_pkg::AUTOVEC_STEP;
  end

  // Level to the core, registered
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      core_level <= 3'h0;
    else
      core_level <= best_key[5:3];
  end

  // Acknowledge answer, one cycle after ack_req
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_done <= 1'b0;
      ack_autovec <= 1'b0;
      ack_vec_offset <= 8'h00;
      ack_source <= 4'h0;
      ack_none <= 1'b0;
      bus_cycle_strobe_block <= 1'b0;
    end
    else
    begin
      ack_done <= ack_req;
      if (ack_req)
      begin
        ack_none <= ~ack_hit;
        ack_source <= ack_idx;
        ack_autovec <= ack_hit & ack_av_sel;
        ack_vec_offset <= (ack_hit & ack_av_sel) ? ack_off_nxt : 8'h00;
        // Strobe blocked only for an autovector cycle
        bus_cycle_strobe_block <= ack_hit & ack_av_sel
          & external_autovector_control_r[irq_prio_pkg::AV_BLOCK_BIT];
      end
      else
        bus_cycle_strobe_block <= 1'b0;
    end
  end

  // ---------------------------------------------
  // Register reads
  // ---------------------------------------------
  // Unmapped addresses read zero
  always_comb
  begin
    rdata_nxt = 32'h0000_0000;
    for (int i = 0; i < irq_prio_pkg::NUM_INT; i++)
      if (reg_addr == irq_prio_pkg::OFS_SRC_CTRL0 + 8'(4 * i))
        rdata_nxt = {24'h000000, source_priority_control_r[i]};
    case (reg_addr)
      irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT: rdata_nxt = {24'h000000, external_autovector_control_r};
      irq_prio_pkg::OFS_LEVEL_ASSIGN: rdata_nxt = {29'h0, external_level_assign_r};
      irq_prio_pkg::OFS_MASK: rdata_nxt = {18'h0, mask_bits_r};
      irq_prio_pkg::OFS_PENDING: rdata_nxt = {18'h0, pending_bits_r};
      irq_prio_pkg::OFS_ACK_INFO: rdata_nxt = {22'h0, best_idx, best_key};
      default: rdata_nxt = rdata_nxt;
    endcase
  end

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
      reg_rdata <= rdata_nxt;
    else
      reg_rdata <= 32'h0000_0000;
  end
endmodule
`default_nettype wire

// [dv/irq_prio_props.sv]
// Assertion checker for the interrupt priority block
`timescale 1ns/100ps
`default_nettype none
module irq_prio_props (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Acknowledge side
  input wire logic ack_req,
  input wire logic [2:0] ack_level,
  input wire logic ack_done,
  input wire logic ack_autovec,
  input wire logic [7:0] ack_vec_offset,
  input wire logic [3:0] ack_source,
  input wire logic ack_none,
  input wire logic bus_cycle_strobe_block
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  // Answer comes exactly one cycle after the request
  property p_ack_pulse;
    ack_req |=> ack_done;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack answer missing");
  property p_ack_only;
    !ack_req |=> !ack_done;
  endproperty
  a_ack_only: assert property (p_ack_only) else $error("ack answer without request");
  // Offset tied to the acknowledged level
  property p_vec;
    ack_done |-> ack_vec_offset == (ack_autovec ? 8'h60 + {3'h0, $past(ack_level), 2'h0} : 8'h00);
  endproperty
  a_vec: assert property (p_vec) else $error("wrong vector offset");
  property p_block;
    bus_cycle_strobe_block |-> ack_done && ack_autovec;
  endproperty
  a_block: assert property (p_block) else $error("strobe blocked outside autovector answer");
  property p_none;
    ack_done && ack_none |-> !ack_autovec && !bus_cycle_strobe_block;
  endproperty
  a_none: assert property (p_none) else $error("empty answer autovectored");
  // External winners only at their mapped levels
  property p_seven;
    ack_done && !ack_none && ack_source == 4'hD |-> $past(ack_level) == 3'h7;
  endproperty
  a_seven: assert property (p_seven) else $error("pin seven won off level seven");
  property p_five;
    ack_done && !ack_none && ack_source == 4'hC |-> $past(ack_level) inside {3'h4, 3'h5};
  endproperty
  a_five: assert property (p_five) else $error("pin five won off its levels");
  property p_three;
    ack_done && !ack_none && ack_source == 4'hB |-> $past(ack_level) inside {3'h3, 3'h6};
  endproperty
  a_three: assert property (p_three) else $error("pin three won off its levels");
  property p_one;
    ack_done && !ack_none && ack_source == 4'hA |-> $past(ack_level) inside {3'h1, 3'h2};
  endproperty
  a_one: assert property (p_one) else $error("pin one won off its levels");
endmodule
bind irq_prio_ctrl irq_prio_props u_props (.clk(clk), .sys_rst(sys_rst), .ack_req(ack_req),
  .ack_level(ack_level), .ack_done(ack_done), .ack_autovec(ack_autovec), .ack_vec_offset(ack_vec_offset),
  .ack_source(ack_source), .ack_none(ack_none), .bus_cycle_strobe_block(bus_cycle_strobe_block));
`default_nettype wire

// [dv/core_model.sv]
// Processor core stand-in that acknowledges one level on command
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Command from the bench
  input wire logic go,
  input wire logic [2:0] lvl,
  // Acknowledge toward the block
  output logic ack_req,
  output logic [2:0] ack_level
);
  // One-cycle pulse; level inverted each cycle outside it, so a stale value matches only on every other cycle
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      ack_req <= 1'b0;
      ack_level <= 3'h0;
    end
    else
    begin
      ack_req <= go;
      ack_level <= go ? lvl : ~ack_level;
    end
endmodule
`default_nettype wire

// [dv/interrupt_priority_autovector_bench.sv]
// Self-checking bench for the interrupt priority block
`timescale 1ns/100ps
`default_nettype none
module interrupt_priority_autovector_bench;
  logic clk, sys_rst, reg_wr, reg_rd, go, rd_d, p7_n, p5_n, p3_n, p1_n;
  logic ack_req, ack_done, ack_autovec, ack_none, strobe_block;
  logic [7:0] reg_addr, ack_vec_offset, external_autovector_control;
  logic [31:0] reg_wdata, reg_rdata;
  logic [9:0] int_req;
  logic [2:0] core_level, ack_level, lvl, lv;
  logic [3:0] ack_source;
  logic [1:0] pr;
  logic av;
  logic [31:0] rd_q[$];
  logic [14:0] ack_q[$];
  int n_mismatch, n_tests, seed, i;
  irq_prio_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .int_req(int_req),
    .ext_request_pin_seven_n(p7_n), .ext_request_pin_five_n(p5_n), .ext_request_pin_three_n(p3_n),
    .ext_request_pin_one_n(p1_n), .core_level(core_level), .ack_req(ack_req), .ack_level(ack_level),
    .ack_done(ack_done), .ack_autovec(ack_autovec), .ack_vec_offset(ack_vec_offset),
    .ack_source(ack_source), .ack_none(ack_none), .bus_cycle_strobe_block(strobe_block));
  core_model u_core (.clk(clk), .sys_rst(sys_rst), .go(go), .lvl(lvl), .ack_req(ack_req), .ack_level(ack_level));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
      begin
        n_mismatch++;
        $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
  endtask
  task automatic final_report;
    $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Gap cycle after each strobe so no signal is set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic ack(input logic [2:0] l, input logic nn, input logic a, input logic [3:0] s);
    ack_q.push_back({nn, a, a ? 8'h60 + {3'h0, l, 2'h0} : 8'h00, s, a & external_autovector_control[0]});
    lvl <= l;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    for (int k = 0; k < 8 && ack_q.size() + rd_q.size() > 0; k++)
      @(posedge clk);
    if (ack_q.size() + rd_q.size() > 0)
      begin
        n_mismatch++;
        final_report();
      end
  endtask
  // Watcher: oldest note against each result as it appears
  always @(posedge clk)
  begin
    rd_d <= reg_rd;
    if (rd_d)
      check(reg_rdata, rd_q.pop_front());
    if (ack_done)
      check({ack_none, ack_autovec, ack_vec_offset, ack_source, strobe_block}, ack_q.pop_front());
  end
  initial
  begin
    {sys_rst, p7_n, p5_n, p3_n, p1_n} = 5'h1F;
    {reg_wr, reg_rd, go, rd_d, lvl, reg_addr, reg_wdata, int_req, external_autovector_control} = '0;
    {n_mismatch, n_tests, seed} = {32'h0, 32'h0, 32'h7c6fd388};
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    // Reset values, write mask, read-only and unmapped places
    rd(irq_prio_pkg::OFS_MASK, 32'h3FFF);
    rd(irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT, 32'h0);
    wr(8'h0C, 32'hFF);
    rd(8'h0C, 32'h9F);
    wr(8'h0C, 32'h14);
    wr(irq_prio_pkg::OFS_PENDING, 32'h3FFF);
    rd(8'h3C, 32'h0);
    int_req[3] <= 1'b1;
    repeat (3) @(posedge clk);
    rd(irq_prio_pkg::OFS_PENDING, 32'h8);
    check({29'h0, core_level}, 32'h0);
    wr(irq_prio_pkg::OFS_MASK, 32'h0);
    // Level launches on the edge the write task returns at; look one edge later
    @(posedge clk);
    check({29'h0, core_level}, 32'h5);
    int_req[3:0] <= 4'h1;
    p7_n <= 1'b0;
    // Pin needs two sync flops, pending and the level flop before it shows
    repeat (4) @(posedge clk);
    // Random level, priority and autovector choices against pin seven
    for (i = 0; i < 16; i++)
    begin
      lv = 3'(32'd1 + {$random(seed)} % 7);
      pr = 2'($random(seed));
      av = 1'($random(seed));
      external_autovector_control = 8'($random(seed));
      wr(irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT, {24'h0, external_autovector_control});
      wr(8'h00, {24'h0, av, 2'b00, lv, pr});
      check({29'h0, core_level}, 32'h7);
      if (lv == 3'h7 && pr[1])
        ack(3'h7, 1'b0, av, 4'h0);
      else
        ack(3'h7, 1'b0, external_autovector_control[7], 4'hD);
      if (lv != 3'h7)
        ack(lv, 1'b0, av, 4'h0);
    end
    {int_req[0], p7_n} <= 2'b01;
    // Order inside level six
    external_autovector_control = 8'h41;
    wr(irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT, 32'h41);
    wr(irq_prio_pkg::OFS_LEVEL_ASSIGN, 32'h2);
    wr(8'h14, 32'h1A);
    wr(8'h10, 32'h19);
    {int_req[5:4], p3_n} <= 3'b110;
    repeat (6) @(posedge clk);
    check({29'h0, core_level}, 32'h6);
    ack(3'h6, 1'b0, 1'b0, 4'h5);
    int_req[5] <= 1'b0;
    repeat (3) @(posedge clk);
    ack(3'h6, 1'b0, 1'b1, 4'hB);
    p3_n <= 1'b1;
    repeat (6) @(posedge clk);
    ack(3'h6, 1'b0, 1'b0, 4'h4);
    int_req[4] <= 1'b0;
    // Pin five and pin one under both assignments
    external_autovector_control = 8'h21;
    wr(irq_prio_pkg::OFS_EXT_AUTOVECTOR_SELECT, 32'h21);
    wr(irq_prio_pkg::OFS_LEVEL_ASSIGN, 32'h4);
    {p5_n, p1_n} <= 2'b00;
    repeat (6) @(posedge clk);
    check({29'h0, core_level}, 32'h4);
    ack(3'h4, 1'b0, 1'b0, 4'hC);
    ack(3'h1, 1'b0, 1'b0, 4'hA);
    wr(irq_prio_pkg::OFS_LEVEL_ASSIGN, 32'h1);
    repeat (3) @(posedge clk);
    check({29'h0, core_level}, 32'h5);
    ack(3'h5, 1'b0, 1'b1, 4'hC);
    ack(3'h2, 1'b0, 1'b0, 4'hA);
    // Masked pin five still pends but no longer reaches the core
    wr(irq_prio_pkg::OFS_MASK, 32'h1000);
    rd(irq_prio_pkg::OFS_PENDING, 32'h1400);
    check({29'h0, core_level}, 32'h2);
    rd(irq_prio_pkg::OFS_ACK_INFO, 32'h292);
    ack(3'h5, 1'b1, 1'b0, 4'h0);
    ack(3'h3, 1'b1, 1'b0, 4'h0);
    final_report();
  end
endmodule
`default_nettype wire
